// ===== core/uem_defines.svh
// Operation
// - Mask register sits at configuration offset 0x108, one bit per error type.
// - A masked error is not captured into the header log.
// - A masked error leaves the first error pointer unchanged.
// - A masked error sends no error report toward the root complex.
// - Masking never stops the matching status bit from being set.
// - Bit 0 is read-write sticky, resets to 0, has no effect; here it masks error 0 from the log and the report.
// - Bit 4 masks data link protocol errors; read-write sticky, reset 0.
// - Surprise down, flow control and completer abort masks read 0.
// - Bit 12 masks poisoned packets; read-write sticky, reset 0.
// - Bit 14 masks completion timeouts; read-write, reset 0, not sticky.
// - Bit 16 masks unexpected completions; read-write sticky, reset 0.
// - Bit 17 masks receiver overflows; read-write sticky, reset 0.
// - Bit 18 masks malformed packets; read-write sticky, reset 0.
// - Status bits set on detection, clear on write of one, sticky.
`ifndef UEM_DEFINES_SVH
`define UEM_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define UEM_OFF_STATUS   12'h104
`define UEM_OFF_MASK     12'h108
`define UEM_OFF_PTR      12'h118
`define UEM_OFF_HDRLOG   12'h11C
`define UEM_OFF_ISTAT    12'h180
`define UEM_OFF_IMASK    12'h184

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define UEM_NUM_ERR      19
`define UEM_BIT_OBSOLETE 0
`define UEM_BIT_LINK     4
`define UEM_BIT_POISON   12
`define UEM_BIT_CPL_TO   14
`define UEM_BIT_UNEXP    16
`define UEM_BIT_RX_OVF   17
`define UEM_BIT_MALF     18
`define UEM_IMPL_BITS    19'h7_5011
`define UEM_STICKY_BITS  19'h7_1011
`define UEM_MASK_RESET   19'h0_0000
`define UEM_STAT_RESET   19'h0_0000
`define UEM_NUM_IRQ      3
`define UEM_IRQ_REPORT   0
`define UEM_IRQ_MASKED   1
`define UEM_IRQ_LOGGED   2
`define UEM_PTR_W        5

`endif

// ===== core/uem_pkg.sv
package uem_pkg;
    typedef logic [18:0] uem_vec_t;
    typedef logic [11:0] uem_addr_t;
    typedef logic [2:0]  uem_irq_t;
endpackage : uem_pkg

// ===== core/uem_mask_cell.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// One mask bit: writable or tied to zero, sticky or cleared by a
// hot reset.
// ****************************************************************
module uem_mask_cell #(
    parameter bit WRITABLE = 1'b1,
    parameter bit STICKY   = 1'b1
) (
    input  wire logic pclk,       // Configuration clock.
    input  wire logic presetn,    // Power-on reset, active low.
    input  wire logic hot_reset,  // Hot or link reset, level.
    input  wire logic wr_en,      // Write strobe for this register.
    input  wire logic wdata,      // Written bit value.
    output var  logic q           // Current mask bit.
);

    // A sticky cell ignores hot reset so masks survive link retraining.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= 1'b0;
        end else if (!WRITABLE) begin
            q <= 1'b0;
        end else if (hot_reset && !STICKY) begin
            q <= 1'b0;
        end else if (wr_en) begin
            q <= wdata;
        end
    end

endmodule : uem_mask_cell
`default_nettype wire

// ===== core/uem_top.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "uem_defines.svh"
module uem_top import uem_pkg::*; #(
    parameter int HDR_W = 32
) (
    input  wire logic        pclk,            // Configuration clock.
    input  wire logic        presetn,         // Fundamental reset, low.
    input  wire logic        hot_reset,       // Hot or link reset.
    input  wire logic        psel,            // APB select.
    input  wire logic        penable,         // APB enable.
    input  wire logic        pwrite,          // APB direction.
    input  wire logic [11:0] paddr,           // APB byte address.
    input  wire logic [31:0] pwdata,          // APB write data.
    output var  logic [31:0] prdata,          // APB read data.
    output var  logic        pready,          // APB ready.
    output var  logic        pslverr,         // APB error.
    input  wire uem_vec_t    err_det,         // Error detect pulses.
    input  wire logic [HDR_W-1:0] err_hdr,    // Header of the packet.
    output var  logic        err_report_q,    // Report pulse to root.
    output var  logic [4:0]  err_report_type, // Reported error index.
    output var  logic [HDR_W-1:0] hdr_log_q,  // Logged header.
    output var  logic [4:0]  first_err_ptr_q, // First error pointer.
    output var  uem_vec_t    err_status_q,    // Status bits.
    output var  logic        irq              // Interrupt, level.
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    // The header log is read through one 32-bit word.
    if (HDR_W < 1 || HDR_W > 32) begin : g_bad_hdr
        $error("HDR_W must be 1 to 32");
    end

    localparam uem_vec_t IMPL   = `UEM_IMPL_BITS;
    localparam uem_vec_t STICKY = `UEM_STICKY_BITS;

    uem_vec_t mask_q;
    uem_irq_t istat_q;
    uem_irq_t imask_q;
    logic     ptr_valid;
    logic     wr_fire;
    logic     rd_fire;
    uem_vec_t live_err;
    uem_vec_t open_err;
    logic [4:0] first_idx;
    logic     any_open;
    logic     hdr_valid_q;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Zero wait states; ready is raised by the setup cycle so that every
    // output comes from a flip-flop.
    assign wr_fire = psel && penable && pready && pwrite;
    assign rd_fire = psel && penable && pready && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable && !pready;
        end
    end

    // Read data and error are sampled in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (paddr == `UEM_OFF_MASK) begin
                prdata <= {13'h0000, mask_q & IMPL};
            end else if (paddr == `UEM_OFF_STATUS) begin
                prdata <= {13'h0000, err_status_q};
            end else if (paddr == `UEM_OFF_PTR) begin
                prdata <= {27'h000_0000, first_err_ptr_q};
            end else if (paddr == `UEM_OFF_HDRLOG) begin
                prdata <= 32'(hdr_log_q);
            end else if (paddr == `UEM_OFF_ISTAT) begin
                prdata <= {29'h0000_0000, istat_q};
            end else if (paddr == `UEM_OFF_IMASK) begin
                prdata <= {29'h0000_0000, imask_q};
            end else begin
                pslverr <= 1'b1;
            end
        end else begin
            pslverr <= 1'b0;
        end
    end

    // ****************************************************************
    // Mask register
    // ****************************************************************
    // Each bit is one cell; unsupported bits are tied to zero and
    // the completion timeout bit is the only one a hot reset clears.
    for (genvar i = 0; i < `UEM_NUM_ERR; i++) begin : g_mask
        uem_mask_cell #(
            .WRITABLE (IMPL[i]),
            .STICKY   (STICKY[i])
        ) u_cell (
            .pclk      (pclk),
            .presetn   (presetn),
            .hot_reset (hot_reset),
            .wr_en     (wr_fire && paddr == `UEM_OFF_MASK),
            .wdata     (pwdata[i]),
            .q         (mask_q[i])
        );
    end

    // ****************************************************************
    // Error status
    // ****************************************************************
    // Detection sets a bit whatever the mask says; a set in the same
    // cycle as a write-one-to-clear wins so no event is lost.
    assign live_err = err_det & IMPL;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_status_q <= `UEM_STAT_RESET;
        end else begin
            for (int i = 0; i < `UEM_NUM_ERR; i++) begin
                if (live_err[i]) begin
                    err_status_q[i] <= 1'b1;
                end else if (wr_fire && paddr == `UEM_OFF_STATUS
                             && pwdata[i]) begin
                    err_status_q[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Header log and first error pointer
    // ****************************************************************
    // Only unmasked errors count; the lowest index wins a tie.
    assign open_err = live_err & ~mask_q;
    assign any_open = |open_err;
    always_comb begin
        first_idx = 5'h00;
        for (int i = `UEM_NUM_ERR - 1; i >= 0; i--) begin
            if (open_err[i]) begin
                first_idx = 5'(i);
            end
        end
    end

    // The log stays locked while the pointed status bit is still set and, for pointer 0, a header was captured.
    assign ptr_valid = err_status_q[first_err_ptr_q] && |first_err_ptr_q
                       || err_status_q[0] && first_err_ptr_q == 5'h00
                          && hdr_valid_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_err_ptr_q <= 5'h00;
            hdr_log_q       <= '0;
            hdr_valid_q     <= 1'b0;
        end else if (any_open && !ptr_valid) begin
            first_err_ptr_q <= first_idx;
            hdr_log_q       <= err_hdr;
            hdr_valid_q     <= 1'b1;
        end else if (!ptr_valid) begin
            hdr_valid_q     <= 1'b0;
        end
    end

    // ****************************************************************
    // Reporting toward the root complex
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_report_q    <= 1'b0;
            err_report_type <= 5'h00;
        end else begin
            err_report_q <= any_open;
            if (any_open) begin
                err_report_type <= first_idx;
            end
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    // Reading clears only the bits that were returned, so an event
    // landing between setup and access is kept.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= 3'h0;
        end else begin
            istat_q[`UEM_IRQ_REPORT] <= any_open ||
                istat_q[`UEM_IRQ_REPORT] && !(rd_fire
                && paddr == `UEM_OFF_ISTAT && prdata[`UEM_IRQ_REPORT]);
            istat_q[`UEM_IRQ_MASKED] <= |(live_err & mask_q) ||
                istat_q[`UEM_IRQ_MASKED] && !(rd_fire
                && paddr == `UEM_OFF_ISTAT && prdata[`UEM_IRQ_MASKED]);
            istat_q[`UEM_IRQ_LOGGED] <= any_open && !ptr_valid ||
                istat_q[`UEM_IRQ_LOGGED] && !(rd_fire
                && paddr == `UEM_OFF_ISTAT && prdata[`UEM_IRQ_LOGGED]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_q <= 3'h0;
        end else if (wr_fire && paddr == `UEM_OFF_IMASK) begin
            imask_q <= pwdata[2:0];
        end
    end

    // The interrupt lags the status by one cycle to come from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat_q & imask_q);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_MASKED_NO_REPORT: assert property (@(posedge pclk)
        disable iff (!presetn)
        (|(live_err & mask_q)) && !any_open |=> !err_report_q)
        else $error("masked error was reported");

    AST_UNMASKED_REPORT: assert property (@(posedge pclk)
        disable iff (!presetn)
        any_open |=> err_report_q && err_report_type == $past(first_idx))
        else $error("unmasked error not reported");

    AST_STATUS_SET: assert property (@(posedge pclk)
        disable iff (!presetn)
        |live_err |=> (err_status_q & $past(live_err)) == $past(live_err))
        else $error("status bit not set on detection");

    AST_PTR_HOLD: assert property (@(posedge pclk)
        disable iff (!presetn)
        !any_open |=> $stable(first_err_ptr_q))
        else $error("pointer moved without an unmasked error");

    AST_HDR_HOLD: assert property (@(posedge pclk)
        disable iff (!presetn)
        !any_open |=> $stable(hdr_log_q))
        else $error("header logged without an unmasked error");

    AST_RO_ZERO: assert property (@(posedge pclk)
        disable iff (!presetn)
        (mask_q & ~IMPL) == 19'h0_0000)
        else $error("unsupported mask bit set");

    AST_HOT_KEEP: assert property (@(posedge pclk)
        disable iff (!presetn)
        hot_reset && !wr_fire |=> mask_q == ($past(mask_q) & STICKY))
        else $error("hot reset handled sticky bits wrongly");

    AST_MASK_WRITE: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_fire && paddr == `UEM_OFF_MASK && !hot_reset
        |=> mask_q == ($past(pwdata[18:0]) & IMPL))
        else $error("mask write not stored");

    AST_RESERVED_READ: assert property (@(posedge pclk)
        disable iff (!presetn)
        rd_fire && paddr == `UEM_OFF_MASK
        |-> prdata[3:1] == 3'h0 && prdata[11:5] == 7'h00)
        else $error("reserved mask bits read nonzero");

    AST_W1C_CLEAR: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_fire && paddr == `UEM_OFF_STATUS && !(|live_err)
        |=> (err_status_q & $past(pwdata[18:0])) == 19'h0_0000)
        else $error("status write one did not clear");

    AST_IRQ_LEVEL: assert property (@(posedge pclk)
        disable iff (!presetn)
        ##1 irq == |($past(istat_q) & $past(imask_q)))
        else $error("interrupt level wrong");

    // Handshake checks: the slave answers in the access cycle and holds
    // ready for one cycle only, so a master never sees a stale answer.
    AST_READY_PULSE: assert property (@(posedge pclk)
        disable iff (!presetn)
        pready |=> !pready)
        else $error("ready stood longer than one cycle");

    AST_READY_AFTER_SETUP: assert property (@(posedge pclk)
        disable iff (!presetn)
        psel && !penable && !pready |=> pready)
        else $error("no ready after a setup cycle");

    AST_ERR_WITH_READY: assert property (@(posedge pclk)
        disable iff (!presetn)
        pslverr |-> pready)
        else $error("error flagged outside an access cycle");

    // Capture checks: an unmasked error with nothing pending takes both
    // the header and its own index in the same edge.
    AST_HDR_CAPTURE: assert property (@(posedge pclk)
        disable iff (!presetn)
        any_open && !ptr_valid |=> hdr_log_q == $past(err_hdr))
        else $error("unmasked error header not logged");

    AST_PTR_CAPTURE: assert property (@(posedge pclk)
        disable iff (!presetn)
        any_open && !ptr_valid |=> first_err_ptr_q == $past(first_idx))
        else $error("unmasked error pointer not taken");

    AST_MASKED_NO_LOG: assert property (@(posedge pclk)
        disable iff (!presetn)
        (|(live_err & mask_q)) && !any_open
        |=> $stable(hdr_log_q) && $stable(first_err_ptr_q))
        else $error("masked error disturbed the log");

    // Event and hold checks: state moves only for its own event, so a stray strobe
    // elsewhere cannot leak into the masks or the status.
    AST_CPL_TO_HOT: assert property (@(posedge pclk)
        disable iff (!presetn)
        hot_reset |=> !mask_q[`UEM_BIT_CPL_TO])
        else $error("hot reset kept the timeout mask");

    AST_STATUS_HOLD: assert property (@(posedge pclk)
        disable iff (!presetn)
        !(|live_err) && !(wr_fire && paddr == `UEM_OFF_STATUS)
        |=> $stable(err_status_q))
        else $error("status moved without an event");

    AST_IMASK_WRITE: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_fire && paddr == `UEM_OFF_IMASK
        |=> imask_q == $past(pwdata[2:0]))
        else $error("interrupt mask write not stored");

    AST_ISTAT_SET: assert property (@(posedge pclk)
        disable iff (!presetn)
        any_open |=> istat_q[`UEM_IRQ_REPORT])
        else $error("report event not flagged");

    AST_MASK_QUIET: assert property (@(posedge pclk)
        disable iff (!presetn)
        !(wr_fire && paddr == `UEM_OFF_MASK) && !hot_reset
        |=> $stable(mask_q))
        else $error("mask moved without a write or reset");

endmodule : uem_top
`default_nettype wire

// ===== tb/uem_root_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Root complex stand-in: counts error reports, keeps the last type.
// ****************************************************************
module uem_root_model (
    input  wire logic       pclk,    // Configuration clock.
    input  wire logic       presetn, // Reset, active low.
    input  wire logic       report,  // Report pulse from the device.
    input  wire logic [4:0] rtype,   // Reported error index.
    output var  logic [7:0] count_q, // Reports received.
    output var  logic [4:0] last_q   // Last reported index.
);
    // The pulse stands one cycle, so each report is counted once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 8'h00;
            last_q  <= 5'h00;
        end else if (report) begin
            count_q <= count_q + 8'h01;
            last_q  <= rtype;
        end
    end
endmodule : uem_root_model
`default_nettype wire

// ===== tb/uem_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uem_defines.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
    $display("[ERR] %0s exp %h got %h", nm, e, s); end end
// ****************************************************************
// Mask register bench: APB driver, queued expectations, monitor.
// ****************************************************************
module uem_top_bench import uem_pkg::*;;
    logic        pclk, presetn, hot_reset, psel, penable, pwrite;
    logic        pready, pslverr, err_report_q, irq;
    uem_addr_t   paddr;
    logic [31:0] pwdata, prdata, err_hdr, hdr_log_q, h;
    uem_vec_t    err_det, err_status_q;
    logic [4:0]  err_report_type, first_err_ptr_q, last_q;
    logic [7:0]  count_q;
    logic [32:0] expq[$];
    logic [4:0]  repq[$];
    int          errors, checks, seed;
    logic [31:0] r;

    uem_top #(.HDR_W(32)) DUT (.pclk(pclk), .presetn(presetn),
        .hot_reset(hot_reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .err_det(err_det),
        .err_hdr(err_hdr), .err_report_q(err_report_q),
        .err_report_type(err_report_type), .hdr_log_q(hdr_log_q),
        .first_err_ptr_q(first_err_ptr_q), .err_status_q(err_status_q),
        .irq(irq));
    uem_root_model root (.pclk(pclk), .presetn(presetn),
        .report(err_report_q), .rtype(err_report_type),
        .count_q(count_q), .last_q(last_q));

    // Free-running 25 ns clock.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Oldest note is matched against each read answer and each report.
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0)
            `CHK("read", expq.pop_front(), {pslverr, prdata})
        if (err_report_q) begin
            `CHK("report due", 1'b1, repq.size() > 0)
            if (repq.size() > 0)
                `CHK("report type", repq.pop_front(), err_report_type)
        end
    end

    // One APB transfer; request held until pready is sampled high.
    task automatic apb(input logic w, input uem_addr_t a,
                       input logic [31:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        if (!w)
            expq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (!pready);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input uem_addr_t a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0_0000_0000);
    endtask : wr

    task automatic rd(input uem_addr_t a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, {1'b0, e});
    endtask : rd

    // One-cycle detect pulse with a random header; header kept in h.
    task automatic fire(input int idx);
        @(posedge pclk);
        h = $random(seed);
        err_det <= uem_vec_t'(1) << idx;
        err_hdr <= h;
        @(posedge pclk);
        err_det <= 19'h0_0000;
        repeat (3) @(posedge pclk);
    endtask : fire

    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // Whole run is well under 1000 cycles; this cuts off a hang.
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        end_sim();
    end

    // Main sequence.
    initial begin
        {presetn, hot_reset, psel, penable, pwrite} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        err_det = 19'h0_0000;
        err_hdr = 32'h0000_0000;
        errors = 0;
        checks = 0;
        seed = 32'h37F40E25;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`UEM_OFF_MASK, 32'h0000_0000);
        rd(`UEM_OFF_STATUS, 32'h0000_0000);
        $display("reset values done");
        wr(`UEM_OFF_MASK, 32'hFFFF_FFFF);
        rd(`UEM_OFF_MASK, 32'h0007_5011);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(`UEM_OFF_MASK, r);
            rd(`UEM_OFF_MASK, r & 32'h0007_5011);
        end
        apb(1'b0, 12'h200, 32'h0000_0000, {1'b1, 32'h0000_0000});
        $display("access done");
        // Masked error: status set, nothing logged or reported.
        wr(`UEM_OFF_MASK, 32'h0007_5011);
        wr(`UEM_OFF_IMASK, 32'h0000_0000);
        fire(`UEM_BIT_LINK);
        `CHK("irq masked", 1'b0, irq)
        `CHK("pointer", 5'h00, first_err_ptr_q)
        rd(`UEM_OFF_STATUS, 32'h0000_0010);
        rd(`UEM_OFF_HDRLOG, 32'h0000_0000);
        wr(`UEM_OFF_IMASK, 32'h0000_0007);
        repeat (2) @(posedge pclk);
        `CHK("irq raised", 1'b1, irq)
        $display("masked error done");
        // Unmasked error: reported, logged, pointer set.
        wr(`UEM_OFF_MASK, 32'h0000_0000);
        repq.push_back(5'd12);
        fire(`UEM_BIT_POISON);
        `CHK("header port", h, hdr_log_q)
        `CHK("status port", 19'h0_1010, err_status_q)
        rd(`UEM_OFF_PTR, 32'h0000_000C);
        rd(`UEM_OFF_HDRLOG, h);
        rd(`UEM_OFF_STATUS, 32'h0000_1010);
        wr(`UEM_OFF_STATUS, 32'h0000_0010);
        rd(`UEM_OFF_STATUS, 32'h0000_1000);
        rd(`UEM_OFF_ISTAT, 32'h0000_0007);
        rd(`UEM_OFF_ISTAT, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        `CHK("root count", 8'h01, count_q)
        `CHK("root type", 5'h0C, last_q)
        $display("reported error done");
        // Hot reset clears only the completion timeout mask.
        wr(`UEM_OFF_MASK, 32'hFFFF_FFFF);
        hot_reset <= 1'b1;
        @(posedge pclk);
        hot_reset <= 1'b0;
        rd(`UEM_OFF_MASK, 32'h0007_1011);
        // Fundamental reset returns sticky bits to zero.
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd(`UEM_OFF_MASK, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        `CHK("notes left", 0, expq.size() + repq.size())
        $display("resets done");
        end_sim();
    end
endmodule : uem_top_bench
`default_nettype wire
